// ---- common/usb_ep1_consts.svh ----
// named offsets, bit positions, reset values and widths for the ep1 bulk-in status block
// assumes inclusion by bare name from the package and the design files
//
// Notes on behaviour
// - any change of the status flags drives the shared usb interrupt request active; here only a flag being set does, and only while unmasked and ep1 is valid
// - status register is read-only, one 8-bit unit; writes leave flags alone
// - writing 0 to a clear register bit forces the matching flag to 0; here a set event in the same cycle wins and the flag stays 1
// - flags are invalid unless endpoint map and current interface support ep1
// - bit 5 set on ep1 IN token answered with NAK; requests interrupt; default 0
// - bit 4 set when ep1 fifo toggles and cpu may write; default 0
// - bit 4 also set on fifo toggle after a zero-length packet
// - bit 4 cleared by hardware on first cpu write to ep1 fifo data
// - ep1 data goes out on the IN token after firmware sets the nak control bit
`ifndef USB_EP1_CONSTS_SVH
`define USB_EP1_CONSTS_SVH

// ****************************************
// register map
// ****************************************
`define EP1_ADDR_W 16
`define EP1_DATA_W 8
`define EP1_STATUS_ADDR 16'hFF29
`define EP1_CLEAR_ADDR 16'hFF2A
`define EP1_MASK_ADDR 16'hFF2B
`define EP1_MAP_ADDR 16'hFF2C
`define EP1_NAK_CTRL_ADDR 16'hFF2E

// ****************************************
// field positions
// ****************************************
`define EP1_NAK_BIT 5
`define EP1_TOGGLE_BIT 4
`define EP1_NAK_CTRL_BIT 0
`define EP1_MAP_EN_BIT 0
`define EP1_MAP_IF_LO 1
`define EP1_MAP_IF_HI 3
`define EP1_IF_W 3

// ****************************************
// reset values
// ****************************************
`define EP1_STATUS_RST 8'h00
`define EP1_MASK_RST 8'h30
`define EP1_MAP_RST 8'h01
`define EP1_USED_MASK 8'h30
`define EP1_ZERO_BYTE 8'h00

`endif

// ---- common/usb_ep1_pkg.sv ----
// types shared by the ep1 bulk-in status block
// assumes the constants header sits beside it on the include path
`include "usb_ep1_consts.svh"

package usb_ep1_pkg;

    // ****************************************
    // in-path sequencer states, gray along idle -> armed -> busy; busy -> idle flips both bits
    // ****************************************
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_armed = 2'b01,
        st_busy = 2'b11
    } in_state_t;

    typedef logic [`EP1_DATA_W-1:0] byte_t;
    typedef logic [`EP1_ADDR_W-1:0] addr_t;
    typedef logic [`EP1_IF_W-1:0] iface_t;

endpackage : usb_ep1_pkg

// ---- design/flag_cell.sv ----
// one sticky status flag with hardware set and clear
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/1ns

module flag_cell (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);

    logic next_flag;

    // set beats clear so an event in the clearing cycle survives
    assign next_flag = set_i ? 1'b1 : (clr_i ? 1'b0 : flag_o);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= next_flag;
        end
    end

endmodule : flag_cell

// ---- design/usb_ep1_bulk_in_int_status.sv ----
// interrupt status logic for the bulk-in endpoint 1 of the usb function unit
// assumes a plain register port with read data one cycle after the read strobe
// assumes usb-side event inputs are one-cycle pulses synchronous to clock_i
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`include "usb_ep1_consts.svh"

module usb_ep1_bulk_in_int_status #(
    parameter int ADDR_W = `EP1_ADDR_W,
    parameter int DATA_W = `EP1_DATA_W
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire usb_ep1_pkg::addr_t addr_i,
    input wire usb_ep1_pkg::byte_t wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire usb_ep1_pkg::iface_t cur_iface_i,
    input wire logic in_token_i,
    input wire logic fifo_toggle_i,
    input wire logic zlp_toggle_i,
    input wire logic fifo_write_i,
    output usb_ep1_pkg::byte_t rdata_o,
    output logic usb_shared_int_req_o,
    output logic in_send_o,
    output logic in_nak_o,
    output logic bulk_in_nak_ctrl_o
);

    import usb_ep1_pkg::*;

    // ****************************************
    // elaboration checks
    // ****************************************
    // the register map is fixed at 16-bit addresses and 8-bit data
    generate
        if (ADDR_W != `EP1_ADDR_W) begin : g_bad_addr
            $error("address width must be 16");
        end
        if (DATA_W != `EP1_DATA_W) begin : g_bad_data
            $error("data width must be 8");
        end
    endgenerate

    // ****************************************
    // declarations
    // ****************************************
    byte_t int_mask;
    byte_t ep1_interface_map;
    in_state_t in_state;
    in_state_t next_in_state;
    logic first_write_pending;
    logic next_first_write_pending;
    logic bulk_in_nak_flag;
    logic bulk_in_toggle_flag;
    byte_t next_rdata;
    logic next_irq;

    // ****************************************
    // address decode
    // ****************************************
    wire hit_status = (addr_i == `EP1_STATUS_ADDR);
    wire hit_clear = (addr_i == `EP1_CLEAR_ADDR);
    wire hit_mask = (addr_i == `EP1_MASK_ADDR);
    wire hit_map = (addr_i == `EP1_MAP_ADDR);
    wire hit_nak_ctrl = (addr_i == `EP1_NAK_CTRL_ADDR);

    // status has no write path at all, so a write there is dropped
    wire wr_clear = write_i & hit_clear;
    wire wr_mask = write_i & hit_mask;
    wire wr_map = write_i & hit_map;
    wire wr_nak_ctrl = write_i & hit_nak_ctrl;

    // ****************************************
    // endpoint validity
    // ****************************************
    wire map_enable = ep1_interface_map[`EP1_MAP_EN_BIT];
    wire [`EP1_IF_W-1:0] map_iface = ep1_interface_map[`EP1_MAP_IF_HI:`EP1_MAP_IF_LO];
    // ep1 only counts while mapped to the interface now selected
    wire ep1_valid = map_enable & (map_iface == cur_iface_i);

    // ****************************************
    // in-token sequencer
    // ****************************************
    wire arm_request = wr_nak_ctrl & wdata_i[`EP1_NAK_CTRL_BIT];
    wire disarm_request = wr_nak_ctrl & ~wdata_i[`EP1_NAK_CTRL_BIT];
    wire token_sends = in_token_i & (in_state == st_armed);
    wire token_naks = in_token_i & (in_state != st_armed);
    wire fifo_toggled = fifo_toggle_i | zlp_toggle_i;

    always_comb begin
        next_in_state = in_state;
        case (in_state)
            st_idle: begin
                if (arm_request) begin
                    next_in_state = st_armed;
                end
            end
            st_armed: begin
                // data leaves on the first IN token after arming
                if (in_token_i) begin
                    next_in_state = st_busy;
                end else if (disarm_request) begin
                    next_in_state = st_idle;
                end
            end
            st_busy: begin
                if (fifo_toggled) begin
                    next_in_state = st_idle;
                end
            end
            default: begin
                next_in_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            in_state <= st_idle;
        end else begin
            in_state <= next_in_state;
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    // a zero written to the clear register drops the flag
    wire clr_nak = wr_clear & ~wdata_i[`EP1_NAK_BIT];
    wire clr_toggle_sw = wr_clear & ~wdata_i[`EP1_TOGGLE_BIT];
    // only the first fifo write after a toggle clears the flag
    wire clr_toggle_hw = fifo_write_i & first_write_pending;

    flag_cell u_nak_flag (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .set_i(token_naks),
        .clr_i(clr_nak),
        .flag_o(bulk_in_nak_flag)
    );

    flag_cell u_toggle_flag (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .set_i(fifo_toggled),
        .clr_i(clr_toggle_sw | clr_toggle_hw),
        .flag_o(bulk_in_toggle_flag)
    );

    assign next_first_write_pending = fifo_toggled ? 1'b1 : (fifo_write_i ? 1'b0 : first_write_pending);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            first_write_pending <= 1'b0;
        end else begin
            first_write_pending <= next_first_write_pending;
        end
    end

    // ****************************************
    // status image
    // ****************************************
    // unused bits are tied low; invalid endpoint reads as all zero
    wire [`EP1_DATA_W-1:0] raw_status = {2'b00, bulk_in_nak_flag, bulk_in_toggle_flag, 4'b0000};
    wire [`EP1_DATA_W-1:0] valid_status = ep1_valid ? raw_status : `EP1_ZERO_BYTE;

    // next-cycle image feeds the request so it rises with the flag change
    wire [`EP1_DATA_W-1:0] next_raw_status = {
        2'b00,
        token_naks | (bulk_in_nak_flag & ~clr_nak),
        fifo_toggled | (bulk_in_toggle_flag & ~(clr_toggle_sw | clr_toggle_hw)),
        4'b0000
    };

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            int_mask <= `EP1_MASK_RST;
        end else if (wr_mask) begin
            int_mask <= wdata_i & `EP1_USED_MASK;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ep1_interface_map <= `EP1_MAP_RST;
        end else if (wr_map) begin
            ep1_interface_map <= wdata_i;
        end
    end

    // ****************************************
    // interrupt request
    // ****************************************
    // level stays up while any unmasked flag is set and ep1 is valid; a firmware clear, the first fifo write or a mask or map write drops it
    assign next_irq = ep1_valid & (|(next_raw_status & int_mask));

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            usb_shared_int_req_o <= 1'b0;
        end else begin
            usb_shared_int_req_o <= next_irq;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // clear register is write-only and reads back as zero
    wire [`EP1_DATA_W-1:0] nak_ctrl_image = {7'b0000000, (in_state == st_armed)};
    wire [`EP1_DATA_W-1:0] read_mux =
        hit_status ? valid_status :
        hit_mask ? int_mask :
        hit_map ? ep1_interface_map :
        hit_nak_ctrl ? nak_ctrl_image :
        `EP1_ZERO_BYTE;

    assign next_rdata = read_i ? read_mux : `EP1_ZERO_BYTE;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= `EP1_ZERO_BYTE;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // ****************************************
    // usb-side answers
    // ****************************************
    // one-cycle send and nak pulses plus the armed level to the packet engine, registered for clean timing
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            in_send_o <= 1'b0;
            in_nak_o <= 1'b0;
            bulk_in_nak_ctrl_o <= 1'b0;
        end else begin
            in_send_o <= token_sends;
            in_nak_o <= token_naks;
            bulk_in_nak_ctrl_o <= (next_in_state == st_armed);
        end
    end

endmodule : usb_ep1_bulk_in_int_status

// ---- sim/usb_host_model.sv ----
// usb host side: sends ep1 IN tokens, toggles the fifo once data went out
// assumes device answers a token one cycle later on in_send_i or not at all
`timescale 1ns/1ns
module usb_host_model (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic zlp_i,
    input wire logic in_send_i,
    output logic in_token_o,
    output logic fifo_toggle_o,
    output logic zlp_toggle_o,
    output logic busy_o
);
    // ****************************************
    // token and toggle sequencing
    // ****************************************
    logic pend;
    logic [2:0] wait_cnt;
    always_ff @(posedge clock_i) begin
        in_token_o <= 1'b0;
        fifo_toggle_o <= 1'b0;
        zlp_toggle_o <= 1'b0;
        if (rst_i) begin
            pend <= 1'b0;
            busy_o <= 1'b0;
            wait_cnt <= 3'h0;
        end else if (go_i) begin
            in_token_o <= 1'b1;
            busy_o <= 1'b1;
        end else if (in_send_i) begin
            pend <= 1'b1;
            // random ack delay, prompt or slow
            wait_cnt <= 3'($urandom_range(0, 4));
        end else if (pend) begin
            if (wait_cnt == 3'h0) begin
                pend <= 1'b0;
                busy_o <= 1'b0;
                fifo_toggle_o <= !zlp_i;
                zlp_toggle_o <= zlp_i;
            end else begin
                wait_cnt <= wait_cnt - 3'h1;
            end
        end else if (busy_o && !in_token_o) begin
            busy_o <= 1'b0;
        end
    end
endmodule : usb_host_model

// ---- sim/usb_ep1_bulk_in_int_status_monitor.sv ----
// port checker for the ep1 bulk-in status block
// assumes one clock domain and the register map of the constants header
`timescale 1ns/1ns
`include "usb_ep1_consts.svh"
module usb_ep1_bulk_in_int_status_checker (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire usb_ep1_pkg::addr_t addr_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire usb_ep1_pkg::iface_t cur_iface_i,
    input wire logic in_token_i,
    input wire logic fifo_toggle_i,
    input wire logic zlp_toggle_i,
    input wire logic fifo_write_i,
    input wire usb_ep1_pkg::byte_t rdata_o,
    input wire logic usb_shared_int_req_o,
    input wire logic in_send_o,
    input wire logic in_nak_o,
    input wire logic bulk_in_nak_ctrl_o
);
    import usb_ep1_pkg::*;
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire logic arm_wr = write_i && addr_i == `EP1_NAK_CTRL_ADDR;
    property p_rd_quiet; !read_i |=> rdata_o == 8'h00; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
    property p_unused; read_i && addr_i == `EP1_STATUS_ADDR |=> (rdata_o & ~`EP1_USED_MASK) == 8'h00; endproperty
    a_unused: assert property (p_unused) else $error("unused status bit set");
    property p_nak_cause; in_nak_o |-> $past(in_token_i); endproperty
    a_nak_cause: assert property (p_nak_cause) else $error("nak without token");
    property p_send_cause; in_send_o |-> $past(in_token_i) && !in_nak_o; endproperty
    a_send_cause: assert property (p_send_cause) else $error("send without token");
    property p_token_answer; in_token_i |=> in_nak_o || in_send_o; endproperty
    a_token_answer: assert property (p_token_answer) else $error("token unanswered");
    property p_irq_rise;
        // mask and map writes reach the request one cycle after the register itself
        $rose(usb_shared_int_req_o) |-> $past(in_token_i || fifo_toggle_i || zlp_toggle_i || write_i)
            || $past(write_i, 2)
            || $past(cur_iface_i) != $past(cur_iface_i, 2) || cur_iface_i != $past(cur_iface_i);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_irq_fall;
        $fell(usb_shared_int_req_o) |-> $past(write_i || fifo_write_i) || $past(write_i, 2)
            || $past(cur_iface_i) != $past(cur_iface_i, 2) || cur_iface_i != $past(cur_iface_i);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without clear");
    property p_arm; $rose(bulk_in_nak_ctrl_o) |-> $past(arm_wr) || $past(arm_wr, 2); endproperty
    a_arm: assert property (p_arm) else $error("armed without write");
    c_nak: cover property (in_nak_o);
    c_send: cover property (in_send_o);
    c_irq: cover property ($rose(usb_shared_int_req_o));
endmodule : usb_ep1_bulk_in_int_status_checker
bind usb_ep1_bulk_in_int_status usb_ep1_bulk_in_int_status_checker i_checker (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(addr_i), .write_i(write_i), .read_i(read_i), .cur_iface_i(cur_iface_i), .in_token_i(in_token_i),
    .fifo_toggle_i(fifo_toggle_i), .zlp_toggle_i(zlp_toggle_i), .fifo_write_i(fifo_write_i), .rdata_o(rdata_o),
    .usb_shared_int_req_o(usb_shared_int_req_o), .in_send_o(in_send_o), .in_nak_o(in_nak_o),
    .bulk_in_nak_ctrl_o(bulk_in_nak_ctrl_o));

// ---- sim/test_usb_ep1_bulk_in_int_status.sv ----
// testbench for the ep1 bulk-in status block with a usb host model
// assumes the register map of the constants header
`timescale 1ns/1ns
`include "usb_ep1_consts.svh"
module test_usb_ep1_bulk_in_int_status;
    import usb_ep1_pkg::*;
    logic clock_i = 0, rst_i = 1, write_i = 0, read_i = 0, go = 0, zlp = 0, fifo_write_i = 0, rd_seen = 0;
    addr_t addr_i = '0;
    byte_t wdata_i = '0;
    iface_t cur_iface_i = '0;
    byte_t rdata_o;
    logic irq, in_send_o, in_nak_o, ctrl, tok, ftog, ztog, busy;
    byte_t exp_q[$];
    int failures = 0, check_count = 0, cycles = 0;
    int nak_cnt = 0, send_cnt = 0;
    always #4 clock_i = ~clock_i;
    usb_ep1_bulk_in_int_status i_usb_ep1_bulk_in_int_status (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .cur_iface_i(cur_iface_i), .in_token_i(tok),
        .fifo_toggle_i(ftog), .zlp_toggle_i(ztog), .fifo_write_i(fifo_write_i), .rdata_o(rdata_o),
        .usb_shared_int_req_o(irq), .in_send_o(in_send_o), .in_nak_o(in_nak_o), .bulk_in_nak_ctrl_o(ctrl));
    usb_host_model i_usb_host_model (.clock_i(clock_i), .rst_i(rst_i), .go_i(go), .zlp_i(zlp),
        .in_send_i(in_send_o), .in_token_o(tok), .fifo_toggle_o(ftog), .zlp_toggle_o(ztog), .busy_o(busy));
    // ****************************************
    // tasks
    // ****************************************
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task chk(input byte_t seen, input byte_t exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input addr_t a, input byte_t d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge clock_i);
        write_i <= 1'b0;
    endtask : wr
    // expected read data goes to the queue, the watcher compares
    task rd(input addr_t a, input byte_t e);
        @(posedge clock_i);
        addr_i <= a;
        read_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock_i);
        read_i <= 1'b0;
    endtask : rd
    task irq_is(input logic e);
        @(posedge clock_i);
        #1 chk(byte_t'(irq), byte_t'(e));
    endtask : irq_is
    task host(input logic z);
        int n;
        n = 0;
        @(posedge clock_i);
        go <= 1'b1;
        zlp <= z;
        @(posedge clock_i);
        go <= 1'b0;
        @(posedge clock_i);
        while (busy === 1'b1 && n < 20) begin
            @(posedge clock_i);
            n++;
        end
    endtask : host
    always @(posedge clock_i) begin
        rd_seen <= read_i;
        if (rd_seen) chk(rdata_o, exp_q.pop_front());
        // answer pulses counted here, compared after the nak test and at the end of the mask and map test
        if (in_nak_o === 1'b1) nak_cnt++;
        if (in_send_o === 1'b1) send_cnt++;
        cycles++;
        if (cycles > 3000) begin
            failures++;
            tally_and_finish();
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hCE00707D));
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(`EP1_STATUS_ADDR, `EP1_STATUS_RST);
        rd(`EP1_MASK_ADDR, `EP1_MASK_RST);
        rd(`EP1_MAP_ADDR, `EP1_MAP_RST);
        rd(`EP1_CLEAR_ADDR, 8'h00);
        rd(16'h0123, 8'h00);
        $display("reset test done");
        host(1'b0);
        rd(`EP1_STATUS_ADDR, 8'h20);
        irq_is(1'b1);
        wr(`EP1_STATUS_ADDR, byte_t'($urandom));
        rd(`EP1_STATUS_ADDR, 8'h20);
        wr(`EP1_CLEAR_ADDR, 8'hEF);
        rd(`EP1_STATUS_ADDR, 8'h20);
        wr(`EP1_CLEAR_ADDR, 8'hDF);
        rd(`EP1_STATUS_ADDR, 8'h00);
        irq_is(1'b0);
        chk(byte_t'(nak_cnt), 8'h01);
        $display("nak test done");
        // arm then disarm with no token between
        wr(`EP1_NAK_CTRL_ADDR, 8'h01);
        rd(`EP1_NAK_CTRL_ADDR, 8'h01);
        wr(`EP1_NAK_CTRL_ADDR, 8'h00);
        rd(`EP1_NAK_CTRL_ADDR, 8'h00);
        for (int z = 0; z < 2; z++) begin
            wr(`EP1_NAK_CTRL_ADDR, 8'h01);
            @(posedge clock_i);
            #1 chk(byte_t'(ctrl), 8'h01);
            host(z[0]);
            chk(byte_t'(ctrl), 8'h00);
            rd(`EP1_STATUS_ADDR, 8'h10);
            irq_is(1'b1);
            @(posedge clock_i);
            fifo_write_i <= 1'b1;
            @(posedge clock_i);
            fifo_write_i <= 1'b0;
            rd(`EP1_STATUS_ADDR, 8'h00);
            irq_is(1'b0);
        end
        $display("toggle test done");
        host(1'b0);
        wr(`EP1_MASK_ADDR, 8'h00);
        irq_is(1'b0);
        wr(`EP1_MASK_ADDR, 8'h20);
        irq_is(1'b1);
        // ep1 mapped to interface 3 while another interface is current
        wr(`EP1_MAP_ADDR, 8'h07);
        cur_iface_i <= iface_t'($urandom_range(0, 2));
        rd(`EP1_STATUS_ADDR, 8'h00);
        irq_is(1'b0);
        cur_iface_i <= 3'h3;
        rd(`EP1_STATUS_ADDR, 8'h20);
        irq_is(1'b1);
        wr(`EP1_CLEAR_ADDR, 8'h00);
        irq_is(1'b0);
        chk(byte_t'(nak_cnt), 8'h02);
        chk(byte_t'(send_cnt), 8'h02);
        $display("mask and map test done");
        tally_and_finish();
    end
endmodule : test_usb_ep1_bulk_in_int_status
